//--- logic/tal_pkg.sv
// Constants of the temperature alert limit and gating block
// Summary of operation
// - Disabled source keeps flag, never raises pin
// - Disabled active alert holds until read/conversion
// - Mask bit 4 gates checksum flag, resets 1
// - Mask bit 3 gates slew flag/status, resets 0
// - Mask bit 2 gates high flag/status, resets 1
// - Mask bit 1 gates low flag/status, resets 1
// - Mask bit 0 gates data-ready flag, resets 0
// - Low threshold bits 15:2, 14-bit signed
// - Low threshold resets to F380h
// - High threshold bits 15:2, resets 2A80h
// - High not above low: limits ignored
// - Threshold bits 1:0 always read zero
// - High release equals high minus hysteresis
// - Low release equals low plus hysteresis
// - Hysteresis register resets to 0A0Ah
// - Mode bit: 0 latched, 1 live
// - High status holds until below release
// - Low status holds until above release
// - Latched flags clear on status read
`default_nettype none
package tal_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_LOW = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_HIGH = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_HYST = 4'h7;
  localparam logic [DATA_W-1:0] RST_MASK = 16'h0016;
  localparam logic [DATA_W-1:0] RST_LOW = 16'hF380;
  localparam logic [DATA_W-1:0] RST_HIGH = 16'h2A80;
  localparam logic [DATA_W-1:0] RST_HYST = 16'h0A0A;
  localparam logic [DATA_W-1:0] MASK_WR_BITS = 16'h001F;
  localparam logic [DATA_W-1:0] LIMIT_WR_BITS = 16'hFFFC;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int SRC_N = 5;
  localparam int SRC_DRDY = 0;
  localparam int SRC_LOW = 1;
  localparam int SRC_HIGH = 2;
  localparam int SRC_SLEW = 3;
  localparam int SRC_CRC = 4;
  localparam int LIMIT_LSB = 2;
  localparam int TEMP_W = 14;
  localparam int HYST_W = 8;
  localparam int HYST_HI_LSB = 8;
  localparam int HYST_LO_LSB = 0;
  // Half a degree is sixteen steps of the temperature scale
  localparam int HYST_SHIFT = 4;
  localparam int CMP_W = 16;
  localparam logic MODE_INTERRUPT = 1'b0;
  localparam logic MODE_COMPARATOR = 1'b1;
endpackage
`default_nettype wire

//--- logic/tal_eval_if.sv
// Signals between register bank and limit evaluator
`default_nettype none
interface tal_eval_if;
  import tal_pkg::*;
  logic conv_stb;
  logic [TEMP_W-1:0] temp;
  logic [TEMP_W-1:0] low_lim;
  logic [TEMP_W-1:0] high_lim;
  logic [HYST_W-1:0] hyst_hi;
  logic [HYST_W-1:0] hyst_lo;
  logic hi_live;
  logic lo_live;
  logic hi_evt;
  logic lo_evt;
  modport bank (output conv_stb, temp, low_lim, high_lim, hyst_hi, hyst_lo,
                input hi_live, lo_live, hi_evt, lo_evt);
  modport eval (input conv_stb, temp, low_lim, high_lim, hyst_hi, hyst_lo,
                output hi_live, lo_live, hi_evt, lo_evt);
endinterface
`default_nettype wire

//--- logic/tal_limit_eval.sv
// Per-conversion threshold and hysteresis evaluator
`default_nettype none
module tal_limit_eval
  import tal_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  tal_eval_if.eval ev
);
  // ****************************************
  // Arithmetic
  // ****************************************
  function automatic logic signed [CMP_W-1:0] sx(input logic [TEMP_W-1:0] v);
    sx = CMP_W'(signed'(v));
  endfunction

  function automatic logic signed [CMP_W-1:0] hx(input logic [HYST_W-1:0] h);
    hx = signed'(CMP_W'({h, HYST_SHIFT'(0)}));
  endfunction

  wire logic signed [CMP_W-1:0] t_w = sx(ev.temp);
  wire logic signed [CMP_W-1:0] lo_w = sx(ev.low_lim);
  wire logic signed [CMP_W-1:0] hi_w = sx(ev.high_lim);
  wire logic signed [CMP_W-1:0] hi_rel_w = hi_w - hx(ev.hyst_hi);
  wire logic signed [CMP_W-1:0] lo_rel_w = lo_w + hx(ev.hyst_lo);
  wire logic limits_ok_w = hi_w > lo_w;
  wire logic eval_w = ev.conv_stb && limits_ok_w;

  logic hi_r;
  logic lo_r;
  logic hi_evt_r;
  logic lo_evt_r;
  wire logic hi_nxt = hi_r ? !(t_w < hi_rel_w) : (t_w > hi_w);
  wire logic lo_nxt = lo_r ? !(t_w > lo_rel_w) : (t_w < lo_w);

  // ****************************************
  // Live status
  // ****************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hi_r <= 1'b0;
      lo_r <= 1'b0;
      hi_evt_r <= 1'b0;
      lo_evt_r <= 1'b0;
    end else begin
      hi_evt_r <= eval_w && (hi_nxt != hi_r);
      lo_evt_r <= eval_w && (lo_nxt != lo_r);
      if (eval_w) begin
        hi_r <= hi_nxt;
        lo_r <= lo_nxt;
      end
    end
  end

  assign ev.hi_live = hi_r;
  assign ev.lo_live = lo_r;
  assign ev.hi_evt = hi_evt_r;
  assign ev.lo_evt = lo_evt_r;
endmodule
`default_nettype wire

//--- logic/tal_alert_top.sv
// Alert mask, limit and hysteresis registers with alert pin gating
`default_nettype none
module tal_alert_top
  import tal_pkg::*;
#(
  parameter int TEMP_BITS = TEMP_W
)
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  input wire logic mode_i,
  input wire logic status_rd_i,
  input wire logic result_rd_i,
  input wire logic conv_done_i,
  input wire logic [DATA_W-1:0] conv_temp_i,
  input wire logic slew_evt_i,
  input wire logic crc_err_i,
  output logic [SRC_N-1:0] flags_o,
  output logic hi_live_o,
  output logic lo_live_o,
  output logic slew_live_o,
  output logic alert_o
);
  // ****************************************
  // Elaboration check
  // ****************************************
  if (TEMP_BITS != TEMP_W) begin : g_bad_width
    $error("temperature width must be 14");
  end

  // ****************************************
  // Register decode
  // ****************************************
  logic [DATA_W-1:0] mask_r;
  logic [DATA_W-1:0] low_r;
  logic [DATA_W-1:0] high_r;
  logic [DATA_W-1:0] hyst_r;
  logic [DATA_W-1:0] rdata_r;

  wire logic wr_mask_w = reg_wr_i && (reg_addr_i == ADDR_MASK);
  wire logic wr_low_w = reg_wr_i && (reg_addr_i == ADDR_LOW);
  wire logic wr_high_w = reg_wr_i && (reg_addr_i == ADDR_HIGH);
  wire logic wr_hyst_w = reg_wr_i && (reg_addr_i == ADDR_HYST);

  wire logic [DATA_W-1:0] mask_nxt = reg_wdata_i & MASK_WR_BITS;
  wire logic [DATA_W-1:0] limit_nxt = reg_wdata_i & LIMIT_WR_BITS;

  logic [DATA_W-1:0] rdata_nxt;
  always_comb begin
    case (reg_addr_i)
      ADDR_MASK: rdata_nxt = mask_r;
      ADDR_LOW: rdata_nxt = low_r;
      ADDR_HIGH: rdata_nxt = high_r;
      ADDR_HYST: rdata_nxt = hyst_r;
      default: rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask_r <= RST_MASK;
      low_r <= RST_LOW;
      high_r <= RST_HIGH;
      hyst_r <= RST_HYST;
    end else begin
      if (wr_mask_w) begin
        mask_r <= mask_nxt;
      end
      if (wr_low_w) begin
        low_r <= limit_nxt;
      end
      if (wr_high_w) begin
        high_r <= limit_nxt;
      end
      if (wr_hyst_w) begin
        hyst_r <= reg_wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_r <= '0;
    end else if (reg_rd_i) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;

  // ****************************************
  // Limit evaluator
  // ****************************************
  tal_eval_if ev_if ();

  assign ev_if.conv_stb = conv_done_i;
  assign ev_if.temp = conv_temp_i[DATA_W-1:LIMIT_LSB];
  assign ev_if.low_lim = low_r[DATA_W-1:LIMIT_LSB];
  assign ev_if.high_lim = high_r[DATA_W-1:LIMIT_LSB];
  assign ev_if.hyst_hi = hyst_r[HYST_HI_LSB +: HYST_W];
  assign ev_if.hyst_lo = hyst_r[HYST_LO_LSB +: HYST_W];

  tal_limit_eval u_eval (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ev(ev_if.eval)
  );

  // ****************************************
  // Latched flags and live slew status
  // ****************************************
  logic [SRC_N-1:0] flag_r;
  logic slew_live_r;

  wire logic [SRC_N-1:0] flag_set_w = {
    crc_err_i,
    conv_done_i && slew_evt_i,
    ev_if.hi_evt,
    ev_if.lo_evt,
    conv_done_i
  };

  // Data-ready also clears on a result read
  wire logic [SRC_N-1:0] flag_clr_w = {
    {(SRC_N-1){status_rd_i}},
    status_rd_i || result_rd_i
  };

  // Set wins over clear; flags set whatever the mask says
  wire logic [SRC_N-1:0] flag_nxt = flag_set_w | (flag_r & ~flag_clr_w);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_r <= '0;
      slew_live_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      if (conv_done_i) begin
        slew_live_r <= slew_evt_i;
      end
    end
  end

  // ****************************************
  // Source selection and pin gating
  // ****************************************
  wire logic comp_w = (mode_i == MODE_COMPARATOR);

  wire logic [SRC_N-1:0] src_w = {
    flag_r[SRC_CRC],
    comp_w ? slew_live_r : flag_r[SRC_SLEW],
    comp_w ? ev_if.hi_live : flag_r[SRC_HIGH],
    comp_w ? ev_if.lo_live : flag_r[SRC_LOW],
    flag_r[SRC_DRDY]
  };

  wire logic [SRC_N-1:0] en_w = mask_r[SRC_N-1:0];
  wire logic gated_w = |(src_w & en_w);

  // Disabling an active source while the pin is up keeps it up
  wire logic hold_set_w = wr_mask_w && alert_o &&
                          (|(src_w & en_w & ~mask_nxt[SRC_N-1:0]));
  wire logic hold_clr_w = status_rd_i || conv_done_i;

  logic hold_r;
  logic alert_r;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_r <= 1'b0;
      alert_r <= 1'b0;
    end else begin
      hold_r <= hold_set_w || (hold_r && !hold_clr_w);
      alert_r <= gated_w || hold_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign alert_o = alert_r;
  assign flags_o = flag_r;
  assign hi_live_o = ev_if.hi_live;
  assign lo_live_o = ev_if.lo_live;
  assign slew_live_o = slew_live_r;
endmodule
`default_nettype wire

//--- tb/tal_alert_props.sv
// Port assertions of the alert limit and gating block
`default_nettype none
module tal_alert_props
  import tal_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire logic status_rd_i,
  input wire logic conv_done_i,
  input wire logic slew_evt_i,
  input wire logic crc_err_i,
  input wire logic [SRC_N-1:0] flags_o,
  input wire logic hi_live_o,
  input wire logic lo_live_o,
  input wire logic slew_live_o,
  input wire logic alert_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  mask_rsv_a: assert property (
    reg_rd_i && reg_addr_i == 4'h4 |=> reg_rdata_o[15:5] == 11'h000) else $error("mask rsv");
  lim_bits_a: assert property (
    reg_rd_i && (reg_addr_i == 4'h5 || reg_addr_i == 4'h6) |=> reg_rdata_o[1:0] == 2'h0)
    else $error("limit low bits");
  crc_flag_a: assert property (crc_err_i |=> flags_o[4]) else $error("crc flag");
  drdy_flag_a: assert property (conv_done_i |=> flags_o[0]) else $error("ready flag");
  slew_live_a: assert property (
    conv_done_i |=> slew_live_o == $past(slew_evt_i)) else $error("slew live");
  live_hold_a: assert property (
    !conv_done_i |=> $stable({hi_live_o, lo_live_o, slew_live_o})) else $error("live moved");
  flag_clr_a: assert property (
    status_rd_i && !conv_done_i && !crc_err_i && !$past(conv_done_i) |=> flags_o == 5'h00)
    else $error("flags not cleared");
  alert_src_a: assert property (
    $rose(alert_o) |-> $past(|{flags_o, hi_live_o, lo_live_o, slew_live_o}))
    else $error("alert without source");
endmodule
bind tal_alert_top tal_alert_props u_props (.clk_i(clk_i), .nrst_i(nrst_i),
  .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .status_rd_i(status_rd_i), .conv_done_i(conv_done_i), .slew_evt_i(slew_evt_i),
  .crc_err_i(crc_err_i), .flags_o(flags_o), .hi_live_o(hi_live_o), .lo_live_o(lo_live_o),
  .slew_live_o(slew_live_o), .alert_o(alert_o));
`default_nettype wire

//--- tb/tal_host.sv
// Host model driving the register port
`default_nettype none
module tal_host
  import tal_pkg::*;
(
  input wire logic clk_i,
  output logic [ADDR_W-1:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [DATA_W-1:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr_o = 4'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 16'h0000;
  end
  task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = w;
    rd_o = !w;
    @(negedge clk_i);
    wr_o = 1'b0;
    rd_o = 1'b0;
    // Released lines show a changed value
    addr_o = ~a;
    wdata_o = ~d;
  endtask
endmodule
`default_nettype wire

//--- tb/tal_alert_top_tb_top.sv
// Self-checking bench of the alert limit and gating block
`default_nettype none
module tal_alert_top_tb_top;
  import tal_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic wr, rd, hl, ll, sl, alert, mode = 1'b0, srd = 1'b0, cdn = 1'b0, slew = 1'b0;
  logic crc = 1'b0, rq = 1'b0, rrd = 1'b0;
  logic [3:0] addr;
  logic [15:0] wd, rdata, d, ct = 16'h0000;
  logic [4:0] flags;
  logic [15:0] q[$];
  int err_count = 0, checks_done = 0, cyc = 0, seed = 32'hB84F;
  always #10 clk_i = ~clk_i;
  tal_host host (.clk_i(clk_i), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wd));
  tal_alert_top dut (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdata), .mode_i(mode),
    .status_rd_i(srd), .result_rd_i(rrd), .conv_done_i(cdn), .conv_temp_i(ct),
    .slew_evt_i(slew), .crc_err_i(crc), .flags_o(flags), .hi_live_o(hl),
    .lo_live_o(ll), .slew_live_o(sl), .alert_o(alert));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rdx(input logic [3:0] a, input logic [15:0] e);
    q.push_back(e);
    host.acc(1'b0, a, 16'h0000);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_i);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask
  task automatic conv(input logic [15:0] t);
    @(negedge clk_i);
    ct = t;
    cdn = 1'b1;
    slew = 1'($random(seed));
    @(negedge clk_i);
    cdn = 1'b0;
    ct = ~t;
    repeat (3) @(negedge clk_i);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Read data watcher
  always @(posedge clk_i) rq <= rd;
  always @(negedge clk_i) begin
    if (rq) chk("rdata", q.pop_front(), rdata);
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    repeat (6) @(negedge clk_i);
    nrst_i = 1'b1;
    rdx(4'h4, 16'h0016);
    rdx(4'h5, 16'hF380);
    rdx(4'h6, 16'h2A80);
    rdx(4'h7, 16'h0A0A);
    $display("reset values done");
    host.acc(1'b1, 4'h4, 16'hFFFF);
    rdx(4'h4, 16'h001F);
    host.acc(1'b1, 4'h5, 16'hFFFF);
    rdx(4'h5, 16'hFFFC);
    repeat (3) begin
      d = 16'($random(seed));
      host.acc(1'b1, 4'h7, d);
      rdx(4'h7, d);
    end
    host.acc(1'b1, 4'h5, 16'hF380);
    host.acc(1'b1, 4'h7, 16'h0A0A);
    host.acc(1'b1, 4'h4, 16'h0004);
    $display("access kinds done");
    conv(16'h2AC0);
    chk("alert", 16'h0001, 16'(alert));
    pulse(srd);
    chk("alert", 16'h0000, 16'(alert));
    conv(16'h2840);
    chk("hi_live", 16'h0001, 16'(hl));
    conv(16'h27C0);
    chk("hi_live", 16'h0000, 16'(hl));
    pulse(srd);
    conv(16'h2AC0);
    host.acc(1'b1, 4'h4, 16'h0000);
    chk("alert", 16'h0001, 16'(alert));
    pulse(srd);
    chk("alert", 16'h0000, 16'(alert));
    conv(16'h27C0);
    chk("flags", 16'h0005, 16'(flags & 5'h05));
    chk("alert", 16'h0000, 16'(alert));
    $display("interrupt mode done");
    host.acc(1'b1, 4'h4, 16'h0002);
    mode = 1'b1;
    conv(16'hF000);
    chk("alert", 16'h0001, 16'(alert));
    conv(16'hF510);
    chk("lo_live", 16'h0001, 16'(ll));
    chk("slew_live", 16'(slew), 16'(sl));
    conv(16'hF610);
    chk("alert", 16'h0000, 16'(alert));
    host.acc(1'b1, 4'h6, 16'hF380);
    conv(16'h2AC0);
    chk("hi_live", 16'h0000, 16'(hl));
    host.acc(1'b1, 4'h4, 16'h0008);
    conv(16'h0000);
    chk("alert", 16'(slew), 16'(alert));
    host.acc(1'b1, 4'h4, 16'h0010);
    pulse(crc);
    chk("alert", 16'h0001, 16'(alert));
    pulse(rrd);
    chk("flags", 16'h0010, 16'(flags & 5'h11));
    $display("comparator mode done");
    conclude();
  end
endmodule
`default_nettype wire
